// >>> hw/i2c_vscale_slave.sv
// Two-wire slave with four registers steering the voltage-scaling sequencer.
// Assumes all pins are asynchronous to CLK_SYS and SDA is an open-drain wire.
`timescale 1ns/1ps
module i2c_vscale_slave (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Serial link
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Device pins
   input wire logic [1:0] ADDRESS_OPTION,
   input wire logic HW_ENABLE,
   input wire logic VOLTAGE_LEVEL_PIN,
   input wire logic CONVERTER_PULSING,
   // Converter and link status
   output logic [5:0] VOUT_LEVEL,
   output logic POWER_GOOD,
   output logic CONVERTER_SOFT_ON,
   output logic HIGH_SPEED_MODE
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [6:0] sync_meta_reg;
   logic [6:0] sync_reg;
   logic scl_d_reg;
   logic sda_d_reg;
   logic hwen_d_reg;
   logic scl_s;
   logic sda_s;
   logic level_pin_s;
   logic hwen_s;
   logic pulsing_s;
   logic [1:0] addr_opt_s;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic hwen_rise;
   vscale_pkg::link_state_e state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic dir_write_reg;
   logic hs_reg;
   logic sda_oe_reg;
   logic sda_out_reg;
   logic [7:0] floor_reg;
   logic [7:0] roof_reg;
   logic [7:0] mode_reg;
   logic [7:0] scaling_reg;
   logic [5:0] sw_target_reg;
   logic soft_on_reg;
   logic addr_match;
   logic master_code;
   logic ptr_valid;
   logic wr_commit;
   logic [7:0] rd_byte;
   logic hw_strategy;
   logic go_done;
   vscale_pkg::ramp_cfg_s ramp_cfg;
   logic [5:0] level;
   logic good;
   logic busy;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync_meta_reg <= 7'h03;
         sync_reg <= 7'h03;
      end
      else
      begin
         sync_meta_reg <= {ADDRESS_OPTION, CONVERTER_PULSING, HW_ENABLE,
                           VOLTAGE_LEVEL_PIN, SDA_IN, SCL_IN};
         sync_reg <= sync_meta_reg;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         hwen_d_reg <= 1'b0;
      end
      else
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         hwen_d_reg <= hwen_s;
      end
   end

   assign scl_s = sync_reg[0];
   assign sda_s = sync_reg[1];
   assign level_pin_s = sync_reg[2];
   assign hwen_s = sync_reg[3];
   assign pulsing_s = sync_reg[4];
   assign addr_opt_s = sync_reg[6:5];
   assign scl_rise = scl_s && !scl_d_reg;
   assign scl_fall = !scl_s && scl_d_reg;
   assign start_seen = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_seen = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   assign hwen_rise = hwen_s && !hwen_d_reg;

   // ----------------------------------------------------------------
   // Address and register decode
   // ----------------------------------------------------------------
   assign addr_match = shift_reg[7:1] == {vscale_pkg::ADDR_FIXED, addr_opt_s};
   assign master_code = shift_reg[7:3] == vscale_pkg::MASTER_CODE_TOP;
   assign ptr_valid = ptr_reg[7:2] == 6'h00;
   assign wr_commit = state_reg == vscale_pkg::ST_WDATA && scl_fall &&
                      bit_cnt_reg == vscale_pkg::BITS_PER_BYTE;

   always_comb
   begin
      rd_byte = vscale_pkg::READ_UNMAPPED;
      if (ptr_valid)
      begin
         case (ptr_reg[1:0])
            vscale_pkg::OFS_FLOOR: rd_byte = floor_reg;
            vscale_pkg::OFS_ROOF: rd_byte = roof_reg;
            vscale_pkg::OFS_MODE: rd_byte = mode_reg;
            default: rd_byte = scaling_reg;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Link protocol
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_reg <= vscale_pkg::ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         dir_write_reg <= 1'b0;
         hs_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end
      else if (start_seen)
      begin
         state_reg <= vscale_pkg::ST_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end
      else if (stop_seen)
      begin
         state_reg <= vscale_pkg::ST_IDLE;
         hs_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            vscale_pkg::ST_ADDR, vscale_pkg::ST_REG, vscale_pkg::ST_WDATA:
            begin
               if (scl_rise)
               begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               else if (scl_fall && bit_cnt_reg == vscale_pkg::BITS_PER_BYTE)
               begin
                  if (state_reg != vscale_pkg::ST_ADDR)
                  begin
                     sda_oe_reg <= 1'b1;
                     if (state_reg == vscale_pkg::ST_REG)
                     begin
                        ptr_reg <= shift_reg;
                        state_reg <= vscale_pkg::ST_REG_ACK;
                     end
                     else
                        state_reg <= vscale_pkg::ST_WDATA_ACK;
                  end
                  else if (master_code)
                  begin
                     hs_reg <= 1'b1;
                     state_reg <= vscale_pkg::ST_IGNORE;
                  end
                  else if (addr_match && hwen_s)
                  begin
                     sda_oe_reg <= 1'b1;
                     dir_write_reg <= shift_reg[0] == vscale_pkg::DIR_TO_DEVICE;
                     state_reg <= vscale_pkg::ST_ADDR_ACK;
                  end
                  else
                     state_reg <= vscale_pkg::ST_IGNORE;
               end
            end
            vscale_pkg::ST_ADDR_ACK, vscale_pkg::ST_RDATA_ACK:
            begin
               if (scl_rise && state_reg == vscale_pkg::ST_RDATA_ACK && sda_s)
                  state_reg <= vscale_pkg::ST_IGNORE;
               else if (scl_fall && state_reg == vscale_pkg::ST_ADDR_ACK && dir_write_reg)
               begin
                  sda_oe_reg <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  state_reg <= vscale_pkg::ST_REG;
               end
               else if (scl_fall)
               begin
                  sda_oe_reg <= !rd_byte[7];
                  shift_reg <= {rd_byte[6:0], 1'b0};
                  bit_cnt_reg <= 4'h1;
                  state_reg <= vscale_pkg::ST_RDATA;
               end
            end
            vscale_pkg::ST_REG_ACK, vscale_pkg::ST_WDATA_ACK:
            begin
               if (scl_fall)
               begin
                  sda_oe_reg <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  state_reg <= vscale_pkg::ST_WDATA;
               end
            end
            vscale_pkg::ST_RDATA:
            begin
               if (scl_fall && bit_cnt_reg == vscale_pkg::BITS_PER_BYTE)
               begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= vscale_pkg::ST_RDATA_ACK;
               end
               else if (scl_fall)
               begin
                  sda_oe_reg <= !shift_reg[7];
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
            end
            default:
               sda_oe_reg <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         sda_out_reg <= 1'b0;
      else
         sda_out_reg <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   assign hw_strategy = scaling_reg[vscale_pkg::STRATEGY_BIT];
   assign go_done = scaling_reg[vscale_pkg::GO_BIT] && !hw_strategy && !busy;

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         floor_reg <= vscale_pkg::FLOOR_RST;
         roof_reg <= vscale_pkg::ROOF_RST;
         mode_reg <= vscale_pkg::MODE_RST;
         scaling_reg <= vscale_pkg::SCALING_RST;
      end
      else if (hwen_rise)
      begin
         floor_reg <= vscale_pkg::FLOOR_RST;
         roof_reg <= vscale_pkg::ROOF_RST;
         mode_reg <= vscale_pkg::MODE_RST;
         scaling_reg <= vscale_pkg::SCALING_RST;
      end
      else if (wr_commit && hwen_s && ptr_valid)
      begin
         case (ptr_reg[1:0])
            vscale_pkg::OFS_FLOOR:
            begin
               floor_reg <= shift_reg;
               roof_reg[7:6] <= shift_reg[7:6];
            end
            vscale_pkg::OFS_ROOF:
            begin
               roof_reg <= shift_reg;
               floor_reg[7:6] <= shift_reg[7:6];
            end
            vscale_pkg::OFS_MODE: mode_reg <= shift_reg;
            default: scaling_reg <= shift_reg;
         endcase
      end
      else if (go_done)
         scaling_reg[vscale_pkg::GO_BIT] <= 1'b0;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         sw_target_reg <= vscale_pkg::ROOF_RST[vscale_pkg::LEVEL_MSB:0];
      else if (hwen_rise)
         sw_target_reg <= vscale_pkg::ROOF_RST[vscale_pkg::LEVEL_MSB:0];
      else if (wr_commit && hwen_s && ptr_valid && ptr_reg[1:0] == vscale_pkg::OFS_SCALING &&
               shift_reg[vscale_pkg::GO_BIT] && !shift_reg[vscale_pkg::STRATEGY_BIT])
         sw_target_reg <= roof_reg[vscale_pkg::LEVEL_MSB:0];
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      ramp_cfg.slew = scaling_reg[vscale_pkg::SLEW_MSB:0];
      ramp_cfg.on = soft_on_reg;
      if (hw_strategy && !level_pin_s)
      begin
         ramp_cfg.target = floor_reg[vscale_pkg::LEVEL_MSB:0];
         ramp_cfg.pulse_frequency_mode = !mode_reg[vscale_pkg::MODE_FLOOR_BIT];
      end
      else if (hw_strategy)
      begin
         ramp_cfg.target = roof_reg[vscale_pkg::LEVEL_MSB:0];
         ramp_cfg.pulse_frequency_mode = !mode_reg[vscale_pkg::MODE_ROOF_BIT];
      end
      else
      begin
         ramp_cfg.target = sw_target_reg;
         ramp_cfg.pulse_frequency_mode = !mode_reg[vscale_pkg::MODE_ROOF_BIT];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         soft_on_reg <= 1'b0;
      else
         soft_on_reg <= hwen_s && floor_reg[vscale_pkg::SOFT_ON_BIT];
   end

   vscale_ramp ramp_u (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .restart(hwen_rise),
      .cfg(ramp_cfg),
      .pulsing(pulsing_s),
      .level_reg(level),
      .good_reg(good),
      .busy(busy)
   );

   assign SDA_OUT = sda_out_reg;
   assign SDA_OE = sda_oe_reg;
   assign VOUT_LEVEL = level;
   assign POWER_GOOD = good;
   assign CONVERTER_SOFT_ON = soft_on_reg;
   assign HIGH_SPEED_MODE = hs_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);

   sequence s_addr_done;
      state_reg == vscale_pkg::ST_ADDR && scl_fall && bit_cnt_reg == vscale_pkg::BITS_PER_BYTE &&
      !start_seen && !stop_seen;
   endsequence

   property p_start_addr;
      start_seen |=> state_reg == vscale_pkg::ST_ADDR && bit_cnt_reg == 4'h0;
   endproperty
   a_start_addr: assert property (p_start_addr)
      else $error("start did not open an address phase");

   property p_ack_match;
      s_addr_done ##0 (addr_match && hwen_s && !master_code) |=>
         sda_oe_reg && state_reg == vscale_pkg::ST_ADDR_ACK;
   endproperty
   a_ack_match: assert property (p_ack_match)
      else $error("matching address not acknowledged");

   property p_ack_held;
      (state_reg == vscale_pkg::ST_ADDR_ACK && scl_s) |-> sda_oe_reg;
   endproperty
   a_ack_held: assert property (p_ack_held)
      else $error("address acknowledge released while clock high");

   property p_stable_high;
      (scl_s && scl_d_reg) |-> $stable(sda_oe_reg);
   endproperty
   a_stable_high: assert property (p_stable_high)
      else $error("data drive changed while clock high");

   property p_stop_idle;
      stop_seen |=> state_reg == vscale_pkg::ST_IDLE && !hs_reg && !sda_oe_reg;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop did not release the link");

   property p_unmapped;
      (state_reg == vscale_pkg::ST_RDATA && !ptr_valid) |-> !sda_oe_reg;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read drove a zero bit");

   property p_master_code;
      s_addr_done ##0 master_code |=> !sda_oe_reg && hs_reg;
   endproperty
   a_master_code: assert property (p_master_code)
      else $error("master code acknowledged or high speed not entered");

   property p_commit;
      (wr_commit && hwen_s && !hwen_rise && ptr_reg == 8'h01) |=>
         roof_reg == $past(shift_reg) && state_reg == vscale_pkg::ST_WDATA_ACK;
   endproperty
   a_commit: assert property (p_commit)
      else $error("data byte not committed on its last falling edge");

   property p_disabled;
      !hwen_s ##1 !hwen_s |-> $stable(mode_reg) && $stable(roof_reg);
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("register changed while enable pin low");

   property p_go_clear;
      (go_done && !wr_commit) |=> !scaling_reg[vscale_pkg::GO_BIT];
   endproperty
   a_go_clear: assert property (p_go_clear)
      else $error("go bit not cleared at target");

   property p_defaults;
      hwen_rise |=> floor_reg == vscale_pkg::FLOOR_RST && scaling_reg == vscale_pkg::SCALING_RST &&
         mode_reg == vscale_pkg::MODE_RST && roof_reg == vscale_pkg::ROOF_RST;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("enable rising did not restore defaults");

   property p_ignore;
      (state_reg == vscale_pkg::ST_IGNORE) |-> !sda_oe_reg;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("unaddressed device drove the data line");

endmodule

// >>> hw/vscale_pkg.sv
// Constants, types and helpers shared by the two-wire slave and its ramp sequencer.
// Assumes a 50 MHz system clock; every pin input is resynchronised inside the slave.
package vscale_pkg;

   // ----------------------------------------------------------------
   // Link addressing
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_FIXED = 5'h12;
   localparam logic [4:0] MASTER_CODE_TOP = 5'h01;
   localparam logic DIR_TO_DEVICE = 1'b1;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] READ_UNMAPPED = 8'hFF;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [1:0] OFS_FLOOR = 2'h0;
   localparam logic [1:0] OFS_ROOF = 2'h1;
   localparam logic [1:0] OFS_MODE = 2'h2;
   localparam logic [1:0] OFS_SCALING = 2'h3;
   localparam int LEVEL_MSB = 5;
   localparam int SOFT_ON_BIT = 7;
   localparam int MODE_FLOOR_BIT = 0;
   localparam int MODE_ROOF_BIT = 1;
   localparam int SLEW_MSB = 2;
   localparam int STRATEGY_BIT = 4;
   localparam int GO_BIT = 7;
   localparam logic [7:0] FLOOR_RST = 8'hC0;
   localparam logic [7:0] ROOF_RST = 8'hC0;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] SCALING_RST = 8'h07;
   localparam logic [2:0] SLEW_SINGLE = 3'h7;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_TIME_NS = 1000;
   localparam logic [11:0] STEP_CYCLES =
      12'((STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_IGNORE
   } link_state_e;

   typedef struct packed {
      logic [5:0] target;
      logic pulse_frequency_mode;
      logic [2:0] slew;
      logic on;
   } ramp_cfg_s;

   // Last count of one micro-step interval for a slew code.
   function automatic logic [11:0] step_last(input logic [2:0] code);
      step_last = (STEP_CYCLES << code) - 12'h001;
   endfunction

endpackage

// >>> hw/vscale_ramp.sv
// Output-level sequencer: moves a digital level toward its target and flags power good.
// Assumes the configuration and pulsing input are already in the system clock domain.
`timescale 1ns/1ps
module vscale_ramp (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic restart,
   input wire vscale_pkg::ramp_cfg_s cfg,
   input wire logic pulsing,
   // State
   output logic [5:0] level_reg,
   output logic good_reg,
   output logic busy
);

   logic [11:0] timer_reg;
   logic pfm_wait_reg;
   logic multi;
   logic step_due;

   assign busy = level_reg != cfg.target;
   assign multi = cfg.slew != vscale_pkg::SLEW_SINGLE;
   assign step_due = timer_reg == vscale_pkg::step_last(cfg.slew);

   // ----------------------------------------------------------------
   // Micro-step timer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         timer_reg <= 12'h000;
      else if (restart || !busy || !multi || step_due)
         timer_reg <= 12'h000;
      else
         timer_reg <= timer_reg + 12'h001;
   end

   // ----------------------------------------------------------------
   // Level update
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         level_reg <= 6'h00;
      else if (restart || !cfg.on)
         level_reg <= 6'h00;
      else if (busy && !multi)
         level_reg <= cfg.target;
      else if (busy && step_due)
      begin
         if (level_reg < cfg.target)
            level_reg <= level_reg + 6'h01;
         else
            level_reg <= level_reg - 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // Power good
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pfm_wait_reg <= 1'b0;
      else if (restart || !cfg.on)
         pfm_wait_reg <= 1'b0;
      else if (busy && !multi && cfg.pulse_frequency_mode && cfg.target < level_reg)
         pfm_wait_reg <= 1'b1;
      else if (pulsing)
         pfm_wait_reg <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         good_reg <= 1'b0;
      else
         good_reg <= cfg.on && !restart && !busy && !pfm_wait_reg;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_multi_low;
      (multi && busy) |=> !good_reg;
   endproperty
   a_multi_low: assert property (p_multi_low)
      else $error("power good high during a multi-step ramp");

   property p_single_jump;
      (!multi && busy && cfg.on && !restart) |=> (level_reg == $past(cfg.target));
   endproperty
   a_single_jump: assert property (p_single_jump)
      else $error("single-step move did not land on target");

   property p_pfm_hold;
      (pfm_wait_reg && !pulsing) |=> !good_reg ##1 !good_reg;
   endproperty
   a_pfm_hold: assert property (p_pfm_hold)
      else $error("power good rose before pulsing resumed");

endmodule

// >>> sim/mst.sv
// Two-wire bus master model.
`timescale 1ns/1ps
module mst (
   input wire logic clk,
   input wire logic sda,
   output logic scl = 1'b1,
   output logic sda_drv = 1'b1
);
   task automatic d(input logic c, input logic s, input int n);
      scl = c;
      sda_drv = s;
      repeat (n) @(negedge clk);
   endtask
   task automatic cond(input logic v);
      d(1'b0, sda_drv, 2);
      d(1'b0, !v, 2);
      d(1'b1, !v, 2);
      d(1'b1, v, 6);
   endtask
   task automatic xfer(input logic [8:0] w, output logic [8:0] r);
      for (int i = 8; i >= 0; i--)
      begin
         d(1'b0, sda_drv, 2);
         d(1'b0, w[i], 2);
         d(1'b1, w[i], 4);
         r[i] = sda;
      end
   endtask
endmodule

// >>> sim/tb_i2c_voltage_scaling_slave.sv
// Bench driving the slave through the master model.
`timescale 1ns/1ps
module tb_i2c_voltage_scaling_slave;
   logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, pin = 1'b0, puls = 1'b0;
   logic [1:0] opt = 2'h2;
   logic oe, scl, mdrv, pg, hs, so, son;
   logic [5:0] lvl;
   logic [8:0] r;
   int error_cnt = 0, total_checks = 0;
   wire sda_w = mdrv & !oe;
   wire [7:0] dw = {vscale_pkg::ADDR_FIXED, opt, vscale_pkg::DIR_TO_DEVICE};
   logic [7:0] dflt [4] = '{8'hC0, 8'hC0, 8'h00, 8'h07};
   logic [7:0] bad [3] = '{8'h93, 8'h00, 8'hF1};
   initial forever #10 clk = ~clk;
   mst i_mst (.clk(clk), .sda(sda_w), .scl(scl), .sda_drv(mdrv));
   i2c_vscale_slave i_i2c_vscale_slave (.CLK_SYS(clk), .RST_N(rst_n), .SCL_IN(scl),
      .SDA_IN(sda_w), .SDA_OUT(so), .SDA_OE(oe), .ADDRESS_OPTION(opt), .HW_ENABLE(en),
      .VOLTAGE_LEVEL_PIN(pin), .CONVERTER_PULSING(puls), .VOUT_LEVEL(lvl), .POWER_GOOD(pg),
      .CONVERTER_SOFT_ON(son), .HIGH_SPEED_MODE(hs));
   task automatic chk(input string n, input logic [7:0] e, g);
      total_checks++;
      error_cnt += int'(g !== e);
      if (g !== e) $display("MISMATCH %s expected %h seen %h", n, e, g);
   endtask
   task automatic tx(input logic [7:0] b, input logic a);
      i_mst.xfer({b, 1'b1}, r);
      chk("ack", {7'h00, a}, {7'h00, !r[0]});
   endtask
   task automatic acc(input logic [7:0] a, v, input logic w);
      i_mst.cond(1'b0);
      tx(dw, 1'b1);
      tx(a, 1'b1);
      if (!w) i_mst.cond(1'b0);
      tx(w ? v : dw ^ 8'h01, 1'b1);
      if (!w) tx(8'hFF, 1'b0);
      if (!w) chk("data", v, r[8:1]);
      i_mst.cond(1'b1);
   endtask
   task automatic nak(input logic [7:0] b);
      i_mst.cond(1'b0);
      tx(b, 1'b0);
      tx(dw, 1'b0);
      i_mst.cond(1'b1);
   endtask
   task automatic lv(input int n, input logic p, u, input logic [5:0] l, input logic g);
      pin = p;
      puls = u;
      i_mst.d(1'b1, 1'b1, n);
      chk("level", {2'h0, l}, {2'h0, lvl});
      chk("good", {7'h00, g}, {7'h00, pg});
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
   initial
   begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      acc(8'h04, 8'hFF, 1'b0);
      foreach (bad[i]) nak(bad[i]);
      i_mst.cond(1'b0);
      tx(8'h0B, 1'b0);
      i_mst.cond(1'b0);
      chk("hs", 8'h01, {7'h00, hs});
      i_mst.cond(1'b1);
      chk("hs", 8'h00, {7'h00, hs});
      opt = 2'h1;
      nak({vscale_pkg::ADDR_FIXED, 2'h2, vscale_pkg::DIR_TO_DEVICE});
      acc(8'h04, 8'hFF, 1'b0);
      opt = 2'h2;
      acc(8'h03, 8'h17, 1'b1);
      acc(8'h00, 8'hC5, 1'b1);
      acc(8'h01, 8'hE0, 1'b1);
      lv(20, 1'b0, 1'b0, 6'h05, 1'b1);
      lv(20, 1'b1, 1'b0, 6'h20, 1'b1);
      lv(20, 1'b0, 1'b0, 6'h05, 1'b0);
      lv(20, 1'b0, 1'b1, 6'h05, 1'b1);
      acc(8'h01, 8'hD2, 1'b1);
      acc(8'h03, 8'h80, 1'b1);
      lv(10, 1'b0, 1'b1, 6'h05, 1'b0);
      lv(900, 1'b0, 1'b1, 6'h12, 1'b1);
      acc(8'h03, 8'h00, 1'b0);
      en = 1'b0;
      nak(dw);
      chk("soft", 8'h00, {7'h00, son});
      en = 1'b1;
      i_mst.d(1'b1, 1'b1, 10);
      foreach (dflt[i]) acc(8'(i), dflt[i], 1'b0);
      lv(20, 1'b0, 1'b1, 6'h00, 1'b1);
      chk("soft", 8'h01, {7'h00, son});
      chk("sda_out", 8'h00, {7'h00, so});
      acc(8'h03, 8'h17, 1'b1);
      acc(8'h00, 8'h09, 1'b1);
      acc(8'h00, 8'h09, 1'b0);
      lv(20, 1'b0, 1'b0, 6'h00, 1'b0);
      acc(8'h00, 8'hC9, 1'b1);
      acc(8'h02, 8'h02, 1'b1);
      lv(20, 1'b1, 1'b0, 6'h00, 1'b1);
      print_verdict();
   end
endmodule
